// ===== core/dcm_monitor.sv
// The implementer's own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ns
module dcm_monitor
    import dcm_pkg::*;
#(
    parameter int SCAN_W = 32,
    parameter int TW     = 16
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [3:0]  safety_in,
    output logic             out_enable_q,
    output logic             disc_error_q,
    output logic             fault_present_q,
    output logic             irq_q,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [DCM_CTRL_MODE_W-1:0] mode_q;
    logic                       run_q;
    logic [DCM_DISC_W-1:0]      disc_q;
    logic [SCAN_W-1:0]          scan_q;
    logic [DCM_EV_W-1:0]        ist_q;
    logic [DCM_EV_W-1:0]        ien_q;
    logic [7:0]                 awaddr_q;
    logic [31:0]                wdata_q;
    logic [3:0]                 wstrb_q;
    logic                       aw_have_q;
    logic                       w_have_q;
    logic                       wr_go;
    logic [DCM_EV_W-1:0]        clr_w;
    logic [DCM_EV_W-1:0]        ev;

    // ---------------------------------------------------------------
    // evaluation state
    // ---------------------------------------------------------------
    logic                       tick;
    logic [3:0]                 in_q;
    logic                       started_q;
    logic                       run_seen_q;
    logic                       idle_seen_q;
    logic                       act_seen_q;
    logic [1:0]                 timing_q;
    logic [1:0]                 expired;
    logic [1:0]                 restart;
    dcm_pair_e                  cls [2];
    dcm_mode_e                  mode;
    logic                       dual;
    logic                       two;
    logic                       cp;
    logic                       err_set;
    logic                       err_clr;
    logic                       all_inactive;
    logic                       all_active;
    logic                       any_discrep;
    logic                       en_raw;
    logic [TW-1:0]              limit;

    assign mode = dcm_mode_e'(mode_q);
    assign dual = (mode != DCM_SINGLE);
    assign two  = (mode == DCM_DUAL_EQ2) || (mode == DCM_DUAL_CP2);
    assign cp   = (mode == DCM_DUAL_CP) || (mode == DCM_DUAL_CP2);
    assign limit = TW'(disc_q);

    dcm_scan_tick #(.CW(SCAN_W)) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .period  (scan_q),
        .tick    (tick)
    );

    // ---------------------------------------------------------------
    // pair classification and enable decode
    // ---------------------------------------------------------------
    always_comb
    begin
        cls[0] = dcm_classify(safety_in[0], safety_in[1], cp);
        cls[1] = two ? dcm_classify(safety_in[2], safety_in[3], cp) : DCM_INACTIVE;
        all_active   = (cls[0] == DCM_ACTIVE) && (!two || cls[1] == DCM_ACTIVE);
        all_inactive = (cls[0] == DCM_INACTIVE) && (cls[1] == DCM_INACTIVE);
        any_discrep  = (cls[0] == DCM_DISCREP) || (cls[1] == DCM_DISCREP);
        unique case (mode)
            DCM_SINGLE:   en_raw = safety_in[0];
            DCM_DUAL_EQ:  en_raw = safety_in[0] & safety_in[1];
            DCM_DUAL_CP:  en_raw = safety_in[0] & ~safety_in[1];
            DCM_DUAL_EQ2: en_raw = &safety_in;
            DCM_DUAL_CP2: en_raw = (safety_in == 4'b0101);
            default:      en_raw = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // discrepancy timers, one per pair
    // ---------------------------------------------------------------
    for (genvar p = 0; p < 2; p++)
    begin : g_pair
        logic disc_now;
        assign disc_now  = (cls[p] == DCM_DISCREP);
        // timer starts when pair turns discrepant, runs while it stays so
        assign restart[p] = tick && disc_now && !timing_q[p];
        dcm_pair_timer #(.TW(TW)) u_tmr (
            .aclk    (aclk),
            .aresetn (aresetn),
            .tick    (tick),
            .restart (restart[p]),
            .running (timing_q[p]),
            .limit   (limit),
            .expired (expired[p]),
            .elapsed ()
        );
        always_ff @(posedge aclk)
        begin
            if (!aresetn || !dual || disc_q == '0)
                timing_q[p] <= 1'b0;
            else if (tick && !disc_now)
                timing_q[p] <= 1'b0;
            else if (tick && disc_now)
                timing_q[p] <= 1'b1;
        end
    end

    // expiry with partner still unchanged; a scan that resolves the pair wins
    // flag once only, else the sticky event could never be cleared
    assign err_set = tick && dual && (disc_q != '0) && !disc_error_q
                     && ((expired[0] && cls[0] == DCM_DISCREP)
                      || (expired[1] && cls[1] == DCM_DISCREP));

    // ---------------------------------------------------------------
    // error release sequence
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            in_q      <= '0;
            started_q <= 1'b0;
        end
        else if (tick)
        begin
            in_q      <= safety_in;
            started_q <= run_q;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !disc_error_q)
        begin
            act_seen_q  <= 1'b0;
            idle_seen_q <= 1'b0;
            run_seen_q  <= 1'b0;
        end
        else
        begin
            if (tick && all_active && !any_discrep)
                act_seen_q <= 1'b1;
            if (!run_q)
                idle_seen_q <= 1'b1;
            if (idle_seen_q && run_q)
                run_seen_q <= 1'b1;
        end
    end

    assign err_clr = tick && act_seen_q && all_inactive && run_seen_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            disc_error_q    <= 1'b0;
            fault_present_q <= 1'b0;
        end
        else if (err_set)
        begin
            disc_error_q    <= 1'b1;
            fault_present_q <= 1'b1;
        end
        else if (err_clr)
        begin
            disc_error_q    <= 1'b0;
            fault_present_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            out_enable_q <= 1'b0;
        else if (tick)
            out_enable_q <= run_q && en_raw && !disc_error_q && !err_set;
    end

    // ---------------------------------------------------------------
    // interrupts
    // ---------------------------------------------------------------
    assign ev[DCM_EV_DERR]  = err_set;
    assign ev[DCM_EV_CLEAR] = err_clr && disc_error_q;
    assign ev[DCM_EV_EDGE]  = tick && (safety_in != in_q);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ist_q <= '0;
        else
            ist_q <= (ist_q & ~clr_w) | ev;   // set beats clear
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_q <= 1'b0;
        else
            irq_q <= |(ist_q & ien_q);
    end

    // ---------------------------------------------------------------
    // axi4-lite write
    // ---------------------------------------------------------------
    assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    assign clr_w = (wr_go && awaddr_q == DCM_OFF_IRQ_CLR && wstrb_q[0])
                   ? wdata_q[DCM_EV_W-1:0] : '0;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= '0;
            wstrb_q       <= '0;
        end
        else
        begin
            s_axi_awready <= !aw_have_q && !s_axi_awready;
            s_axi_wready  <= !w_have_q && !s_axi_wready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            unique case (awaddr_q)
                DCM_OFF_CTRL, DCM_OFF_DISC, DCM_OFF_IRQ_EN,
                DCM_OFF_IRQ_CLR, DCM_OFF_SCAN: s_axi_bresp <= RESP_OK;
                default:                       s_axi_bresp <= RESP_ERR;
            endcase
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= DCM_CTRL_MODE_W'(DCM_SINGLE);
            run_q  <= 1'b0;
            disc_q <= DCM_DISC_DEF_STEPS;
            ien_q  <= '0;
            scan_q <= SCAN_W'(DCM_SCAN_CYC);
        end
        else if (wr_go && wstrb_q[0])
        begin
            unique case (awaddr_q)
                DCM_OFF_CTRL:
                begin
                    if (wdata_q[DCM_CTRL_MODE_W-1:0] <= DCM_CTRL_MODE_W'(DCM_DUAL_CP2))
                        mode_q <= wdata_q[DCM_CTRL_MODE_W-1:0];
                    run_q <= wdata_q[DCM_CTRL_RUN_BIT];
                end
                DCM_OFF_DISC:
                    if (wdata_q[DCM_DISC_W-1:0] <= DCM_DISC_MAX_STEPS)
                        disc_q <= wdata_q[DCM_DISC_W-1:0];
                DCM_OFF_IRQ_EN: ien_q  <= wdata_q[DCM_EV_W-1:0];
                DCM_OFF_SCAN:   scan_q <= wdata_q[SCAN_W-1:0];
                default:        ;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // axi4-lite read
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OK;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OK;
            s_axi_rdata   <= '0;
            unique case (s_axi_araddr)
                DCM_OFF_CTRL:
                    s_axi_rdata <= {27'h000_0000, run_q, 1'b0, mode_q};
                DCM_OFF_DISC:    s_axi_rdata <= 32'(disc_q);
                DCM_OFF_STATUS:
                    s_axi_rdata <= {27'h000_0000, started_q, |timing_q,
                                    fault_present_q, disc_error_q, out_enable_q};
                DCM_OFF_IRQ_ST:  s_axi_rdata <= 32'(ist_q);
                DCM_OFF_IRQ_EN:  s_axi_rdata <= 32'(ien_q);
                DCM_OFF_IRQ_CLR: s_axi_rdata <= '0;
                DCM_OFF_SCAN:    s_axi_rdata <= 32'(scan_q);
                default:         s_axi_rresp <= RESP_ERR;
            endcase
        end
        else
            s_axi_arready <= 1'b1;
    end
endmodule // dcm_monitor

// ===== core/dcm_pair_timer.sv
`timescale 1ns/1ns
module dcm_pair_timer
    import dcm_pkg::*;
#(
    parameter int TW = 16
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic          tick,
    input  wire logic          restart,
    input  wire logic          running,
    input  wire logic [TW-1:0] limit,
    output logic               expired,
    output logic [TW-1:0]      elapsed
);
    // ---------------------------------------------------------------
    // discrepancy timer in scan units
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || restart || !running)
            elapsed <= '0;
        else if (tick && elapsed != {TW{1'b1}})
            elapsed <= elapsed + TW'(1);
    end

    // expiry once elapsed exceeds the setting: lands in (set, set+step]
    assign expired = running && (elapsed > limit);
endmodule // dcm_pair_timer

// ===== core/dcm_scan_tick.sv
`timescale 1ns/1ns
module dcm_scan_tick
    import dcm_pkg::*;
#(
    parameter int CW = 32
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire logic [CW-1:0] period,
    output logic               tick
);
    logic [CW-1:0] cnt_q;

    // ---------------------------------------------------------------
    // scan cycle divider
    // ---------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else if (cnt_q + CW'(1) >= period)
        begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + CW'(1);
            tick  <= 1'b0;
        end
    end
endmodule // dcm_scan_tick

// ===== shared/dcm_pkg.sv
package dcm_pkg;
    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] DCM_OFF_CTRL    = 8'h00;
    localparam logic [7:0] DCM_OFF_DISC    = 8'h04;
    localparam logic [7:0] DCM_OFF_STATUS  = 8'h08;
    localparam logic [7:0] DCM_OFF_IRQ_ST  = 8'h0C;
    localparam logic [7:0] DCM_OFF_IRQ_EN  = 8'h10;
    localparam logic [7:0] DCM_OFF_IRQ_CLR = 8'h14;
    localparam logic [7:0] DCM_OFF_SCAN    = 8'h18;

    // ctrl fields
    localparam int DCM_CTRL_MODE_LSB = 0;
    localparam int DCM_CTRL_MODE_W   = 3;
    localparam int DCM_CTRL_RUN_BIT  = 4;

    // status fields
    localparam int DCM_ST_ENABLE_BIT = 0;
    localparam int DCM_ST_DERR_BIT   = 1;
    localparam int DCM_ST_FAULT_BIT  = 2;
    localparam int DCM_ST_TIMING_BIT = 3;
    localparam int DCM_ST_ARM_BIT    = 4;

    // interrupt event bits
    localparam int DCM_EV_DERR  = 0;
    localparam int DCM_EV_CLEAR = 1;
    localparam int DCM_EV_EDGE  = 2;
    localparam int DCM_EV_W     = 3;

    // ---------------------------------------------------------------
    // input type
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        DCM_SINGLE   = 3'h0,
        DCM_DUAL_EQ  = 3'h1,
        DCM_DUAL_CP  = 3'h2,
        DCM_DUAL_EQ2 = 3'h3,
        DCM_DUAL_CP2 = 3'h4
    } dcm_mode_e;

    typedef enum logic [1:0] {
        DCM_INACTIVE = 2'h0,
        DCM_ACTIVE   = 2'h1,
        DCM_DISCREP  = 2'h2
    } dcm_pair_e;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int  DCM_CLK_HZ         = 250_000_000;
    localparam int  DCM_STEP_MS        = 10;
    localparam int  DCM_DISC_MAX_MS    = 30_000;
    localparam int  DCM_DISC_DEF_MS    = 30;
    localparam int  DCM_DISC_W         = 12;
    localparam logic [DCM_DISC_W-1:0] DCM_DISC_DEF_STEPS =
        DCM_DISC_W'(DCM_DISC_DEF_MS / DCM_STEP_MS);
    localparam logic [DCM_DISC_W-1:0] DCM_DISC_MAX_STEPS =
        DCM_DISC_W'(DCM_DISC_MAX_MS / DCM_STEP_MS);
    // default scan period in ms
    localparam int  DCM_SCAN_MS        = 4;
    localparam longint DCM_SCAN_CYC    =
        (longint'(DCM_CLK_HZ) / 1000) * DCM_SCAN_MS;
    localparam int  DCM_RESET_W        = 2;

    // classify a pair by input type
    function automatic dcm_pair_e dcm_classify(input logic nc, input logic b,
                                               input logic cp);
        logic act;
        logic inact;
        act   = cp ? (nc & ~b) : (nc & b);
        inact = cp ? (~nc & b) : (~nc & ~b);
        if (act)
            return DCM_ACTIVE;
        else if (inact)
            return DCM_INACTIVE;
        return DCM_DISCREP;
    endfunction
endpackage

// ===== tb/dcm_checker.sv
`timescale 1ns/1ns
module dcm_checker (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [3:0]  safety_in,
    input wire logic        out_enable_q,
    input wire logic        disc_error_q,
    input wire logic        fault_present_q,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid
);
    // ----------------------------------------
    // write tracking: aw and w may land apart
    // ----------------------------------------
    logic aw_q, w_q, clr, go;
    assign clr = !aresetn || (s_axi_bvalid && s_axi_bready);
    assign go  = (aw_q || (s_axi_awvalid && s_axi_awready)) &&
                 (w_q || (s_axi_wvalid && s_axi_wready)) && !(aw_q && w_q);
    always_ff @(posedge aclk)
        aw_q <= clr ? 1'b0 : aw_q | (s_axi_awvalid & s_axi_awready);
    always_ff @(posedge aclk)
        w_q <= clr ? 1'b0 : w_q | (s_axi_wvalid & s_axi_wready);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_err_fault; disc_error_q |-> fault_present_q; endproperty
    a_err_fault: assert property (p_err_fault) else $error("error without fault");
    property p_err_off; disc_error_q |-> !out_enable_q; endproperty
    a_err_off: assert property (p_err_off) else $error("enable during error");
    property p_en_nc; $rose(out_enable_q) |-> $past(safety_in[0]); endproperty
    a_en_nc: assert property (p_en_nc) else $error("enable, input one low");
    property p_err_rise; $rose(disc_error_q) |-> !$past(out_enable_q); endproperty
    a_err_rise: assert property (p_err_rise) else $error("error from enable");
    property p_err_fall; $fell(disc_error_q) |-> !$past(safety_in[0]); endproperty
    a_err_fall: assert property (p_err_fall) else $error("clear while active");
    property p_fault_fall; $fell(fault_present_q) |-> $fell(disc_error_q); endproperty
    a_fault_fall: assert property (p_fault_fall) else $error("fault cleared alone");
    property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
    property p_wr_lat; go |-> ##[1:2] s_axi_bvalid; endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write answer late");

    c_err: cover property ($rose(disc_error_q));
    c_en: cover property ($rose(out_enable_q));
    c_clr: cover property ($fell(disc_error_q));
endmodule // dcm_checker

// ===== tb/dcm_field_model.sv
`timescale 1ns/1ns
module dcm_field_model (
    input wire logic        aclk,
    input wire logic [3:0]  tgt,
    input wire logic [15:0] lag,
    output logic [3:0]      safety_in
);
    // ----------------------------------------
    // partner contact lags by lag cycles; all ones holds it back for 65535 cycles
    // ----------------------------------------
    logic [15:0] cnt_q;
    initial
    begin
        safety_in = 4'h0;
        cnt_q = 16'h0;
    end
    always @(posedge aclk)
    begin
        safety_in[0] <= tgt[0];
        safety_in[2] <= tgt[2];
        if ({safety_in[3], safety_in[1]} == {tgt[3], tgt[1]})
            cnt_q <= 16'h0;
        else if (cnt_q >= lag)
        begin
            safety_in[1] <= tgt[1];
            safety_in[3] <= tgt[3];
            cnt_q <= 16'h0;
        end
        else
            cnt_q <= cnt_q + 16'h1;
    end
endmodule // dcm_field_model

// ===== tb/dual_channel_discrepancy_monitor_tb.sv
`timescale 1ns/1ns
module dual_channel_discrepancy_monitor_tb
    import dcm_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [3:0]  safety_in, tgt, p, s_axi_wstrb;
    logic [15:0] lag, lf;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        out_enable_q, disc_error_q, fault_present_q, irq_q;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] rq_d[$], rq_m[$];
    logic [1:0]  rq_r[$], bq[$];
    int          fails, check_count, i, m;

    always #2 aclk = ~aclk;

    dcm_monitor DUT (.aclk, .aresetn, .safety_in, .out_enable_q, .disc_error_q, .fault_present_q,
        .irq_q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    dcm_field_model u_fld (.aclk, .tgt, .lag, .safety_in);

    // ----------------------------------------
    // reporting and bus tasks
    // ----------------------------------------
    task tally_and_finish;
        $display("mismatches %0d, comparisons %0d", fails, check_count);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task cmp(input logic [31:0] a, input logic [31:0] e, input string s);
        check_count++;
        if (a !== e)
        begin
            fails++;
            $display("[FAIL] %0t %s", $time, s);
        end
    endtask
    task pin(input logic a, input logic e);
        cmp({31'h0, a}, {31'h0, e}, "output level");
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task hang(input int n);
        if (n >= 100)
        begin
            cmp(32'h0, 32'h1, "no bus answer");
            tally_and_finish;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        int   n;
        bq.push_back(er);
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (aw && s_axi_awready) begin aw = 1'b0; s_axi_awvalid <= 1'b0; end
            if (w && s_axi_wready) begin w = 1'b0; s_axi_wvalid <= 1'b0; end
            if (s_axi_bvalid) break;
        end
        hang(n);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] k, input logic [1:0] er);
        logic ar;
        int   n;
        rq_d.push_back(e);
        rq_m.push_back(k);
        rq_r.push_back(er);
        ar = 1'b1;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 100; n++)
        begin
            @(posedge aclk);
            if (ar && s_axi_arready) begin ar = 1'b0; s_axi_arvalid <= 1'b0; end
            if (!ar && s_axi_rvalid) break;
        end
        hang(n);
        s_axi_rready <= 1'b0;
    endtask
    function automatic logic ee(input int md, input logic [3:0] v);
        case (md)
            0: return v[0];
            1: return v[0] & v[1];
            2: return v[0] & ~v[1];
            3: return &v;
            default: return v == 4'b0101;
        endcase
    endfunction

    always @(posedge aclk)
    begin
        if (s_axi_rvalid && s_axi_rready && rq_d.size() > 0)
        begin
            cmp(s_axi_rdata & rq_m.pop_front(), rq_d.pop_front(), "read data");
            cmp({30'h0, s_axi_rresp}, {30'h0, rq_r.pop_front()}, "read response");
        end
        if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
            cmp({30'h0, s_axi_bresp}, {30'h0, bq.pop_front()}, "write response");
    end

    // ----------------------------------------
    // main sequence; scan period cut to 4 cycles, one disc step per scan
    // ----------------------------------------
    initial
    begin
        fails = 0;
        check_count = 0;
        lf = 16'he377;
        tgt = 4'h0;
        lag = 16'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        cyc(4);
        aresetn <= 1'b1;
        rd(DCM_OFF_CTRL, 32'h0, 32'h1f, 2'b00);
        rd(DCM_OFF_DISC, 32'h3, 32'hfff, 2'b00);
        rd(8'h1c, 32'h0, 32'hffff_ffff, 2'b10);
        wr(8'h1c, 32'h1, 2'b10);
        wr(DCM_OFF_DISC, 32'hbb8, 2'b00);
        wr(DCM_OFF_DISC, 32'hbb9, 2'b00);
        rd(DCM_OFF_DISC, 32'hbb8, 32'hfff, 2'b00);
        wr(DCM_OFF_SCAN, 32'h4, 2'b00);
        wr(DCM_OFF_IRQ_EN, 32'h1, 2'b00);
        for (m = 0; m < 5; m++)
        begin
            wr(DCM_OFF_CTRL, 32'h10 | m, 2'b00);
            wr(DCM_OFF_DISC, (m == 0) ? 32'h1 : 32'h0, 2'b00);
            for (i = 0; i < 24; i++)
            begin
                lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
                p = (i < 16) ? i[3:0] : lf[3:0];
                tgt <= p;
                cyc(14);
                pin(out_enable_q, ee(m, p));
                pin(disc_error_q, 1'b0);
            end
        end
        wr(DCM_OFF_CTRL, 32'h11, 2'b00);
        wr(DCM_OFF_DISC, 32'h2, 2'b00);
        tgt <= 4'h0;
        cyc(12);
        lag <= 16'hffff;
        tgt <= 4'h3;
        cyc(5);
        pin(disc_error_q, 1'b0);
        cyc(20);
        pin(disc_error_q, 1'b1);
        pin(fault_present_q, 1'b1);
        rd(DCM_OFF_STATUS, 32'h6, 32'h7, 2'b00);
        rd(DCM_OFF_IRQ_ST, 32'h1, 32'h1, 2'b00);
        pin(irq_q, 1'b1);
        wr(DCM_OFF_IRQ_EN, 32'h0, 2'b00);
        cyc(2);
        pin(irq_q, 1'b0);
        wr(DCM_OFF_IRQ_EN, 32'h1, 2'b00);
        cyc(2);
        pin(irq_q, 1'b1);
        wr(DCM_OFF_IRQ_CLR, 32'h1, 2'b00);
        cyc(2);
        pin(irq_q, 1'b0);
        rd(DCM_OFF_IRQ_CLR, 32'h0, 32'hffff_ffff, 2'b00);
        // no idle/run yet: error stays
        lag <= 16'h0;
        tgt <= 4'h3;
        cyc(12);
        tgt <= 4'h0;
        cyc(12);
        pin(disc_error_q, 1'b1);
        wr(DCM_OFF_CTRL, 32'h01, 2'b00);
        wr(DCM_OFF_CTRL, 32'h11, 2'b00);
        tgt <= 4'h3;
        cyc(12);
        tgt <= 4'h0;
        cyc(12);
        pin(disc_error_q, 1'b0);
        pin(fault_present_q, 1'b0);
        lag <= 16'h5;
        tgt <= 4'h3;
        cyc(20);
        pin(disc_error_q, 1'b0);
        pin(out_enable_q, 1'b1);
        tgt <= 4'h0;
        cyc(20);
        lag <= 16'h0;
        wr(DCM_OFF_DISC, 32'h3, 2'b00);
        for (i = 0; i < 5; i++)
        begin
            tgt <= {3'h0, ~i[0]};
            cyc(8);
        end
        pin(disc_error_q, 1'b0);
        for (i = 0; i < 4; i++)
        begin
            tgt <= i[0] ? 4'h2 : 4'h1;
            cyc(8);
        end
        pin(disc_error_q, 1'b1);
        tally_and_finish;
    end
endmodule // dual_channel_discrepancy_monitor_tb

bind dcm_monitor dcm_checker u_chk (.aclk, .aresetn, .safety_in, .out_enable_q, .disc_error_q,
    .fault_present_q, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
